// >>> logic/pwm_pkg.sv
// Shared constants and carrier types for the pulse width unit.
// Assumes one 20 MHz clock and a synchronous active-low reset.
// How it works
// - Four independent generators plus one shared output control stage.
// - Every generator drives two outputs that may run independently.
// - Optionally the two outputs form a complementary pair with dead bands.
// - Each generator has its own interrupt and trigger output.
// - Control stage sets polarity, pin enable, sync, fault kill, status.
// - Each generator has one 16-bit down or up/down counter, two compares.
// - Eight pins; pins 2g and 2g+1 belong to generator g.
// - Comparator A sets the pulse width of the even pin.
// - Comparator B sets the pulse width of the odd pin.
// - Down mode counts period to zero, then reloads: left aligned.
// - Up/down mode counts zero to period and back: center aligned.
// - Sync mode holds new values until a software sync event.
// - New period and widths take effect only with the counter at zero.
`default_nettype none
package pwm_pkg;
  localparam int NGEN = 4;
  localparam int NPIN = 8;
  localparam int AW   = 8;
  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_SYNC   = 8'h04;
  localparam logic [7:0] OFF_OUTEN  = 8'h08;
  localparam logic [7:0] OFF_INVERT = 8'h0C;
  localparam logic [7:0] OFF_FSUP   = 8'h10;
  localparam logic [7:0] OFF_ISTAT  = 8'h14;
  localparam logic [7:0] OFF_ICLR   = 8'h18;
  localparam logic [7:0] OFF_IEN    = 8'h1C;
  // Generator g sits at (g + GEN_FIRST) * 16, word offsets below.
  localparam logic [3:0] GEN_FIRST  = 4'h2;
  localparam logic [3:0] GEN_LAST   = 4'h5;
  localparam logic [3:0] OFF_LOAD   = 4'h0;
  localparam logic [3:0] OFF_CMPA   = 4'h4;
  localparam logic [3:0] OFF_CMPB   = 4'h8;
  localparam logic [3:0] OFF_DBAND  = 4'hC;
  // Field positions of the control register and the fault bit of the status register.
  localparam int CTRL_EN   = 0;
  localparam int CTRL_UD   = 4;
  localparam int CTRL_SYNC = 8;
  localparam int CTRL_DB   = 12;
  localparam int IST_FAULT = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] CNT_ZERO   = 16'h0000;

  // Counter direction, one-hot.
  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } dir_t;

  // Period, compare and dead band values of one generator.
  typedef struct packed {
    logic [15:0] load;
    logic [15:0] cmpa;
    logic [15:0] cmpb;
    logic [15:0] rise;
    logic [15:0] fall;
  } gen_cfg_t;

  // Mode bits of one generator.
  typedef struct packed {
    logic en;
    logic updown;
    logic dband;
  } gen_mode_t;
endpackage
`default_nettype wire

// >>> logic/pwm_gen.sv
// One generator: counter, two comparators and dead band stage.
// Assumes the shadow values and update permission come from the control stage.
`default_nettype none
module pwm_gen (
  // Clock and reset.
  input  wire logic           aclk,
  input  wire logic           aresetn,
  // Configuration.
  input  wire pwm_pkg::gen_mode_t mode,
  input  wire pwm_pkg::gen_cfg_t  shadow,
  input  wire logic           upd_ok,
  // Status and waveforms.
  output logic                upd_took,
  output logic                zero_pulse,
  output logic                first_pair_output,
  output logic                second_pair_output
);
  import pwm_pkg::*;

  typedef struct packed {
    gen_cfg_t    cfg;
    logic [15:0] cnt;
    dir_t        dir;
    logic [15:0] dcnt;
    logic        aq;
    logic        a;
    logic        b;
    logic        zero;
    logic        took;
  } gstate_t;

  gstate_t s;
  gstate_t n;
  logic [15:0] lp;
  logic        araw;
  logic        braw;

  ////////////////////////////////////////////////////////////////////////
  // Counter, compare and dead band next state.
  always_comb begin
    n      = s;
    n.zero = 1'b0;
    n.took = 1'b0;
    lp     = upd_ok ? shadow.load : s.cfg.load;
    araw   = mode.en && (s.cnt >= s.cfg.cmpa);
    braw   = mode.en && (s.cnt >= s.cfg.cmpb);
    if (mode.en) begin
      if (s.cnt == CNT_ZERO) begin
        n.zero = 1'b1;
        if (upd_ok) begin
          n.cfg  = shadow;
          n.took = 1'b1;
        end
        if (mode.updown) begin
          n.cnt = (lp == CNT_ZERO) ? CNT_ZERO : 16'h0001;
          n.dir = DIR_UP;
        end else begin
          n.cnt = lp;
          n.dir = DIR_DOWN;
        end
      end else if (mode.updown && s.dir == DIR_UP) begin
        if (s.cnt >= s.cfg.load) begin
          n.dir = DIR_DOWN;
          n.cnt = s.cnt - 16'h0001;
        end else begin
          n.cnt = s.cnt + 16'h0001;
        end
      end else begin
        n.cnt = s.cnt - 16'h0001;
      end
    end
    // Dead band: after each edge of A both outputs rest low for a count.
    if (!mode.en || !mode.dband) begin
      n.dcnt = CNT_ZERO;
      n.aq   = araw;
      n.a    = araw;
      n.b    = braw;
    end else begin
      if (araw != s.aq) begin
        n.aq   = araw;
        n.dcnt = araw ? s.cfg.rise : s.cfg.fall;
      end else if (s.dcnt != CNT_ZERO) begin
        n.dcnt = s.dcnt - 16'h0001;
      end
      n.a = n.aq && (n.dcnt == CNT_ZERO);
      n.b = !n.aq && (n.dcnt == CNT_ZERO);
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from flip-flops.
  assign upd_took           = s.took;
  assign zero_pulse         = s.zero;
  assign first_pair_output  = s.a;
  assign second_pair_output = s.b;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence a_dropped;
    mode.dband && $fell(s.a);
  endsequence

  chk_down_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    mode.en && !mode.updown && s.cnt == CNT_ZERO && !upd_ok
    |=> s.cnt == $past(s.cfg.load))
    else $error("down counter did not reload the period");
  chk_down_step: assert property (@(posedge aclk) disable iff (!aresetn)
    mode.en && !mode.updown && s.cnt != CNT_ZERO
    |=> s.cnt == $past(s.cnt) - 16'h0001)
    else $error("down counter did not step by one");
  chk_updown_peak: assert property (@(posedge aclk) disable iff (!aresetn)
    mode.en && mode.updown && s.dir == DIR_UP && s.cnt != CNT_ZERO
    && s.cnt >= s.cfg.load |=> s.dir == DIR_DOWN)
    else $error("up/down counter missed its turn at the period");
  chk_update_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(s.cfg) |-> $past(s.cnt) == CNT_ZERO && s.took)
    else $error("values changed away from zero");
  chk_disabled_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !mode.en |=> $stable(s.cnt) && !s.a && !s.b)
    else $error("disabled generator moved or drove");
  chk_dead_gap: assert property (@(posedge aclk) disable iff (!aresetn)
    a_dropped ##0 (s.cfg.fall != CNT_ZERO) |-> !s.b)
    else $error("pair output rose without dead band");
endmodule // pwm_gen
`default_nettype wire

// >>> logic/pwm_unit.sv
// Pulse width unit top: register slave, four generators, output control.
// Assumes an AXI4-Lite master on aclk and a synchronous fault input.
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`default_nettype none
module pwm_unit (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data.
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response.
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read.
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Fault input, high while the power stage reports a fault.
  input  wire logic        fault_in,
  // Pins pin_out_zero to pin_out_seven.
  output logic [7:0]       pin_out,
  // Per generator interrupt and trigger, shared interrupt.
  output logic [3:0]       gen_irq,
  output logic [3:0]       gen_trig,
  output logic             irq
);
  import pwm_pkg::*;

  typedef struct packed {
    logic                  aw_ok;
    logic                  w_ok;
    logic [7:0]            waddr;
    logic [31:0]           wd;
    logic [3:0]            ws;
    logic                  bv;
    logic [1:0]            br;
    logic                  rv;
    logic [1:0]            rr;
    logic [31:0]           rd;
    logic [15:0]           ctrl;
    logic [7:0]            outen;
    logic [7:0]            inv;
    logic [7:0]            sup;
    logic [4:0]            ien;
    logic [4:0]            ist;
    logic [3:0]            pend;
    gen_cfg_t [NGEN-1:0]   cfg;
    logic [7:0]            pins;
  } tstate_t;

  tstate_t   s;
  tstate_t   n;
  logic [3:0] upd_ok;
  logic [3:0] took;
  logic [3:0] zero;
  logic [7:0] raw;
  gen_mode_t [NGEN-1:0] mode;

  ////////////////////////////////////////////////////////////////////////
  // Address decoding helpers, shared by the read and write paths, and the byte-enable merge of the write path.

  // True for any mapped register word.
  function automatic logic addr_mapped(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    if (a[7:4] >= GEN_FIRST && a[7:4] <= GEN_LAST) begin
      hit = 1'b1;
    end else if (a[7:2] <= OFF_IEN[7:2]) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // True when the word belongs to a generator block.
  function automatic logic addr_is_gen(input logic [7:0] a);
    return (a[7:4] >= GEN_FIRST) && (a[7:4] <= GEN_LAST);
  endfunction

  // Generator number of a generator word.
  function automatic logic [1:0] gen_of(input logic [7:0] a);
    logic [3:0] d;
    d = a[7:4] - GEN_FIRST;
    return d[1:0];
  endfunction

  // Applies byte enables to a 32-bit value.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Generator instances generator_block_zero to generator_block_three.
  generate
    for (genvar g = 0; g < NGEN; g++) begin : g_gen
      assign mode[g].en     = s.ctrl[CTRL_EN + g];
      assign mode[g].updown = s.ctrl[CTRL_UD + g];
      assign mode[g].dband  = s.ctrl[CTRL_DB + g];
      // Sync mode waits for a pending sync event; otherwise free.
      assign upd_ok[g] = !s.ctrl[CTRL_SYNC + g] || s.pend[g];

      pwm_gen u_gen (
        .aclk               (aclk),
        .aresetn            (aresetn),
        .mode               (mode[g]),
        .shadow             (s.cfg[g]),
        .upd_ok             (upd_ok[g]),
        .upd_took           (took[g]),
        .zero_pulse         (zero[g]),
        .first_pair_output  (raw[2*g]),
        .second_pair_output (raw[2*g+1])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Next state of the register file, bus slave and pin stage.
  always_comb begin
    logic [31:0] rv;
    logic [31:0] cur;
    logic [4:0]  clr;
    logic [3:0]  syn;
    logic [1:0]  g;
    rv  = 32'h0000_0000;
    cur = 32'h0000_0000;
    clr = 5'h00;
    syn = 4'h0;
    g   = 2'h0;
    n   = s;

    // Capture write address and data in either order.
    if (awvalid && !s.aw_ok) begin
      n.aw_ok = 1'b1;
      n.waddr = awaddr;
    end
    if (wvalid && !s.w_ok) begin
      n.w_ok = 1'b1;
      n.wd   = wdata;
      n.ws   = wstrb;
    end
    if (bready) begin
      n.bv = 1'b0;
    end

    // Perform a write once both halves are held and no answer waits.
    if (s.aw_ok && s.w_ok && !s.bv) begin
      n.aw_ok = 1'b0;
      n.w_ok  = 1'b0;
      n.bv    = 1'b1;
      n.br    = addr_mapped(s.waddr) ? RESP_OKAY : RESP_SLVERR;
      if (addr_is_gen(s.waddr)) begin
        g = gen_of(s.waddr);
        unique case (s.waddr[3:0])
          OFF_LOAD: begin
            cur = merge({16'h0000, s.cfg[g].load}, s.wd, s.ws);
            n.cfg[g].load = cur[15:0];
          end
          OFF_CMPA: begin
            cur = merge({16'h0000, s.cfg[g].cmpa}, s.wd, s.ws);
            n.cfg[g].cmpa = cur[15:0];
          end
          OFF_CMPB: begin
            cur = merge({16'h0000, s.cfg[g].cmpb}, s.wd, s.ws);
            n.cfg[g].cmpb = cur[15:0];
          end
          OFF_DBAND: begin
            cur = merge({s.cfg[g].fall, s.cfg[g].rise}, s.wd, s.ws);
            n.cfg[g].rise = cur[15:0];
            n.cfg[g].fall = cur[31:16];
          end
          default: begin
            cur = 32'h0000_0000;
          end
        endcase
      end else begin
        unique case (s.waddr[7:2])
          OFF_CTRL[7:2]: begin
            cur    = merge({16'h0000, s.ctrl}, s.wd, s.ws);
            n.ctrl = cur[15:0];
          end
          OFF_SYNC[7:2]: begin
            cur = merge(32'h0000_0000, s.wd, s.ws);
            syn = cur[3:0];
          end
          OFF_OUTEN[7:2]: begin
            cur     = merge({24'h000000, s.outen}, s.wd, s.ws);
            n.outen = cur[7:0];
          end
          OFF_INVERT[7:2]: begin
            cur   = merge({24'h000000, s.inv}, s.wd, s.ws);
            n.inv = cur[7:0];
          end
          OFF_FSUP[7:2]: begin
            cur   = merge({24'h000000, s.sup}, s.wd, s.ws);
            n.sup = cur[7:0];
          end
          OFF_ICLR[7:2]: begin
            cur = merge(32'h0000_0000, s.wd, s.ws);
            clr = cur[4:0];
          end
          OFF_IEN[7:2]: begin
            cur   = merge({27'h0000000, s.ien}, s.wd, s.ws);
            n.ien = cur[4:0];
          end
          default: begin
            cur = 32'h0000_0000;
          end
        endcase
      end
    end

    // Read path: one outstanding read, answer one cycle later.
    if (rready) begin
      n.rv = 1'b0;
    end
    if (arvalid && !s.rv) begin
      if (addr_is_gen(araddr)) begin
        g = gen_of(araddr);
        unique case (araddr[3:0])
          OFF_LOAD:  rv = {16'h0000, s.cfg[g].load};
          OFF_CMPA:  rv = {16'h0000, s.cfg[g].cmpa};
          OFF_CMPB:  rv = {16'h0000, s.cfg[g].cmpb};
          OFF_DBAND: rv = {s.cfg[g].fall, s.cfg[g].rise};
          default:   rv = 32'h0000_0000;
        endcase
      end else begin
        unique case (araddr[7:2])
          OFF_CTRL[7:2]:   rv = {16'h0000, s.ctrl};
          OFF_OUTEN[7:2]:  rv = {24'h000000, s.outen};
          OFF_INVERT[7:2]: rv = {24'h000000, s.inv};
          OFF_FSUP[7:2]:   rv = {24'h000000, s.sup};
          OFF_ISTAT[7:2]:  rv = {27'h0000000, s.ist};
          OFF_IEN[7:2]:    rv = {27'h0000000, s.ien};
          default:         rv = 32'h0000_0000;
        endcase
      end
      n.rv = 1'b1;
      n.rd = rv;
      n.rr = addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end

    // Sync events: a new request wins over the clear by the generator.
    n.pend = (s.pend & ~took) | syn;

    // Sticky status: a new event wins over a software clear.
    n.ist = (s.ist & ~clr) | {fault_in, zero};

    // Output stage: polarity, pin enable and fault suppression.
    for (int i = 0; i < NPIN; i++) begin
      n.pins[i] = s.outen[i] && !(fault_in && s.sup[i])
                  && (raw[i] ^ s.inv[i]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port drive.
  assign awready  = !s.aw_ok;
  assign wready   = !s.w_ok;
  assign bvalid   = s.bv;
  assign bresp    = s.br;
  assign arready  = !s.rv;
  assign rvalid   = s.rv;
  assign rdata    = s.rd;
  assign rresp    = s.rr;
  assign pin_out  = s.pins;
  assign gen_trig = zero;
  assign gen_irq  = s.ist[3:0] & s.ien[3:0];
  assign irq      = |(s.ist & s.ien);

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_pin_pass: assert property (@(posedge aclk) disable iff (!aresetn)
    s.outen[1] && !fault_in && (raw[1] ^ s.inv[1]) |=> pin_out[1])
    else $error("generator zero odd output did not reach pin one");
  chk_fault_kill: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_in && s.sup[0] |=> !pin_out[0] ##1 irq || !s.ien[IST_FAULT])
    else $error("fault did not silence pin zero");
  chk_sync_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    took[3] |-> $past(s.pend[3]) || !$past(s.ctrl[CTRL_SYNC + 3]))
    else $error("sync generator updated without a sync event");
  chk_fault_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_in && s.ien[IST_FAULT] |=> irq [*2])
    else $error("fault interrupt not raised");
endmodule // pwm_unit
`default_nettype wire

// >>> verification/power_stage_model.sv
// Behavioural model of the power switching stages that the pins drive.
// Assumes pins settle after the rising edge of aclk; faults come only on request.
`default_nettype none
module power_stage_model (
  // Clock.
  input  wire logic       aclk,
  // Pin inputs and the pairs that must never conduct together.
  input  wire logic [7:0] pin_out,
  input  wire logic [3:0] pair_mask,
  // Fault report, raised only when the bench asks for one.
  input  wire logic       fault_req,
  output logic            fault_in,
  output logic            overlap_seen
);
  ////////////////////////////////////////////////////////////////////////////
  // Report faults one cycle late and latch any shoot-through on a guarded pair.
  initial begin
    fault_in     = 1'b0;
    overlap_seen = 1'b0;
    forever begin
      @(posedge aclk);
      fault_in <= fault_req;
      for (int g = 0; g < 4; g++) begin
        if (pair_mask[g] && pin_out[2*g] && pin_out[2*g+1]) begin
          overlap_seen <= 1'b1;
        end
      end
    end
  end
endmodule // power_stage_model
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the pulse width unit.
// Assumes the package, the unit and the power stage model are compiled first.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pwm_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, fault_in, irq, fault_req, overlap_seen;
  logic [7:0]  awaddr, araddr, pin_out;
  logic [31:0] wdata, rdata, rd_val, ctrl;
  logic [3:0]  wstrb, gen_irq, gen_trig;
  logic [1:0]  bresp, rresp;
  int          mismatches, checks_done, hi[8], trg[4];

  pwm_unit uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .fault_in(fault_in), .pin_out(pin_out), .gen_irq(gen_irq), .gen_trig(gen_trig),
    .irq(irq));
  power_stage_model stage (.aclk(aclk), .pin_out(pin_out), .pair_mask(4'h4),
    .fault_req(fault_req), .fault_in(fault_in), .overlap_seen(overlap_seen));

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 20 MHz.
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Counts a comparison and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One AXI4-Lite write; each channel is released at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic       da, dw, db, ha, hw;
    logic [1:0] rs;
    da = 0;
    dw = 0;
    db = 0;
    rs = 2'h1;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 40 && !db; n++) begin
      @(negedge aclk);
      ha = awready;
      hw = wready;
      db = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (!da && ha) begin
        awvalid <= 1'b0;
        da = 1;
      end
      if (!dw && hw) begin
        wvalid <= 1'b0;
        dw = 1;
      end
      if (db) begin
        bready <= 1'b0;
      end
    end
    chk("bresp", {30'h0, er}, {30'h0, rs});
  endtask

  // One AXI4-Lite read into rd_val.
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    logic       da, dr;
    logic [1:0] rs;
    da = 0;
    dr = 0;
    rs = 2'h1;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 40 && !dr; n++) begin
      @(negedge aclk);
      if (!da && arready) begin
        da = 1;
      end
      dr     = rvalid;
      rd_val = rdata;
      rs     = rresp;
      @(posedge aclk);
      if (da) begin
        arvalid <= 1'b0;
      end
      if (dr) begin
        rready <= 1'b0;
      end
    end
    chk("rresp", {30'h0, er}, {30'h0, rs});
  endtask

  // Writes one register of generator g.
  task automatic gw(input int g, input logic [3:0] off, input logic [31:0] d);
    wr(8'h20 + 8'(g * 16) + {4'h0, off}, d, RESP_OKAY);
  endtask

  // Counts high cycles of each pin and trigger pulses over n cycles.
  task automatic meas(input int n);
    hi  = '{default: 0};
    trg = '{default: 0};
    repeat (n) begin
      @(negedge aclk);
      for (int p = 0; p < 8; p++) hi[p] += int'(pin_out[p]);
      for (int g = 0; g < 4; g++) trg[g] += int'(gen_trig[g]);
    end
  endtask

  // Reset values, write-only read-back and unmapped addresses.
  task automatic t_reset;
    rd(OFF_CTRL, RESP_OKAY);
    chk("ctrl", 32'h0, rd_val);
    rd(OFF_ISTAT, RESP_OKAY);
    chk("istat", 32'h0, rd_val);
    rd(OFF_SYNC, RESP_OKAY);
    chk("sync", 32'h0, rd_val);
    rd(8'h60, RESP_SLVERR);
    wr(8'h60, 32'hFFFF_FFFF, RESP_SLVERR);
    chk("pins", 32'h0, {24'h0, pin_out});
  endtask

  // Generator zero counting down; other pins stay idle until inverted.
  task automatic t_down;
    gw(0, OFF_LOAD, 32'h9);
    gw(0, OFF_CMPA, 32'h4);
    gw(0, OFF_CMPB, 32'h6);
    wr(OFF_OUTEN, 32'hFF, RESP_OKAY);
    ctrl = 32'h1;
    wr(OFF_CTRL, ctrl, RESP_OKAY);
    meas(30);
    meas(20);
    chk("pin0", 32'd12, hi[0]);
    chk("pin1", 32'd8, hi[1]);
    chk("trig0", 32'd2, trg[0]);
    for (int p = 2; p < 8; p++) chk("idle", 32'd0, hi[p]);
    wr(OFF_INVERT, 32'h4, RESP_OKAY);
    meas(20);
    chk("inv2", 32'd20, hi[2]);
    wr(OFF_INVERT, 32'h0, RESP_OKAY);
  endtask

  // Generator one counting up and down, period sixteen cycles.
  task automatic t_updown;
    gw(1, OFF_LOAD, 32'h8);
    gw(1, OFF_CMPA, 32'h4);
    gw(1, OFF_CMPB, 32'h2);
    ctrl = ctrl | 32'h22;
    wr(OFF_CTRL, ctrl, RESP_OKAY);
    meas(40);
    meas(32);
    chk("pin2", 32'd18, hi[2]);
    chk("pin3", 32'd26, hi[3]);
  endtask

  // Generator two as a complementary pair with rise 2 and fall 3.
  task automatic t_dband;
    gw(2, OFF_LOAD, 32'd19);
    gw(2, OFF_CMPA, 32'd10);
    gw(2, OFF_DBAND, 32'h0003_0002);
    ctrl = ctrl | 32'h4004;
    wr(OFF_CTRL, ctrl, RESP_OKAY);
    meas(45);
    meas(40);
    chk("pin4", 32'd16, hi[4]);
    chk("pin5", 32'd14, hi[5]);
    chk("overlap", 32'd0, {31'h0, overlap_seen});
  endtask

  // Generator three holds a new width until a sync event.
  task automatic t_sync;
    gw(3, OFF_LOAD, 32'h9);
    gw(3, OFF_CMPA, 32'h4);
    ctrl = ctrl | 32'h8;
    wr(OFF_CTRL, ctrl, RESP_OKAY);
    meas(30);
    meas(20);
    chk("pin6", 32'd12, hi[6]);
    ctrl = ctrl | 32'h800;
    wr(OFF_CTRL, ctrl, RESP_OKAY);
    gw(3, OFF_CMPA, 32'h8);
    meas(40);
    chk("held", 32'd24, hi[6]);
    meas(20);
    chk("pin6", 32'd12, hi[6]);
    wr(OFF_SYNC, 32'h8, RESP_OKAY);
    meas(30);
    meas(20);
    chk("pin6", 32'd4, hi[6]);
  endtask

  // Fault kill, fault status, interrupt masking and clearing.
  task automatic t_irq;
    wr(OFF_FSUP, 32'h1, RESP_OKAY);
    wr(OFF_IEN, 32'h10, RESP_OKAY);
    @(posedge aclk);
    fault_req <= 1'b1;
    meas(4);
    rd(OFF_ISTAT, RESP_OKAY);
    chk("fault", 32'h10, rd_val & 32'h10);
    chk("irq", 32'h1, {31'h0, irq});
    meas(20);
    chk("kill0", 32'd0, hi[0]);
    chk("pin1", 32'd8, hi[1]);
    @(posedge aclk);
    fault_req <= 1'b0;
    meas(3);
    wr(OFF_ICLR, 32'h10, RESP_OKAY);
    rd(OFF_ISTAT, RESP_OKAY);
    chk("fclr", 32'h0, rd_val & 32'h10);
    chk("irq", 32'h0, {31'h0, irq});
    wr(OFF_IEN, 32'h1, RESP_OKAY);
    meas(12);
    chk("girq0", 32'h1, {31'h0, gen_irq[0]});
    chk("irq", 32'h1, {31'h0, irq});
    wr(OFF_IEN, 32'h0, RESP_OKAY);
    meas(2);
    chk("irq", 32'h0, {31'h0, irq});
    wr(OFF_FSUP, 32'h0, RESP_OKAY);
  endtask

  // Disabling generator zero stops its pins and its trigger.
  task automatic t_disable;
    ctrl = ctrl & 32'hFFFF_FFFE;
    wr(OFF_CTRL, ctrl, RESP_OKAY);
    meas(3);
    meas(32);
    chk("pin0", 32'd0, hi[0]);
    chk("pin1", 32'd0, hi[1]);
    chk("trig0", 32'd0, trg[0]);
    chk("pin2", 32'd18, hi[2]);
  endtask

  // Prints the verdict and ends the run.
  task automatic complete_run;
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, fault_req} = '0;
    {awaddr, araddr} = '0;
    wdata = '0;
    wstrb = 4'hF;
    mismatches = 0;
    checks_done = 0;
    ctrl = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_down;
    t_updown;
    t_dband;
    t_sync;
    t_irq;
    t_disable;
    complete_run;
  end

  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    complete_run;
  end
endmodule // testbench
`default_nettype wire
